// File: rtl/hall_lin_pkg.sv
package hall_lin_pkg;

   // register word indices; byte address is four times the index
   localparam logic [5:0] IDX_SENS_TRIM  = 6'h03;
   localparam logic [5:0] IDX_TC1        = 6'h04;
   localparam logic [5:0] IDX_TC2        = 6'h05;
   localparam logic [5:0] IDX_QO         = 6'h06;
   localparam logic [5:0] IDX_DRIFT      = 6'h07;
   localparam logic [5:0] IDX_LIN_FIRST  = 6'h0A;
   localparam logic [5:0] IDX_LIN_LAST   = 6'h12;
   localparam logic [5:0] IDX_STATUS     = 6'h20;

   localparam int REG_W       = 26;
   localparam int NUM_WORDS   = 9;
   localparam int NUM_ENTRIES = 17;
   localparam int NUM_BINS    = 8;

   // field positions
   localparam int POL_BIT        = 15;
   localparam int COARSE_LSB     = 12;
   localparam int COARSE_W       = 3;
   localparam int FINE_LSB       = 0;
   localparam int FINE_W         = 11;
   localparam int TC2_W          = 10;
   localparam int TC1_W          = 11;
   localparam int COOL_LSB       = 12;
   localparam int QO_W           = 18;
   localparam int DRIFT_W        = 12;
   localparam int ENTRY_W        = 13;
   localparam int ODD_LSB        = 13;
   localparam int LIN_EN_BIT     = 13;
   localparam int BIN_MODE_BIT   = 14;
   localparam int OUT_INV_BIT    = 15;
   localparam int IN_INV_BIT     = 16;
   localparam int HYST_LSB       = 17;
   localparam int HYST_W         = 8;
   localparam int SCALE_BIT      = 25;

   // reset values
   localparam logic [25:0] SENS_TRIM_RST = 26'h0000400;
   localparam logic [25:0] WORD_RST      = 26'h0000000;

   // arithmetic scaling
   localparam int TC2_DIV     = 1000;
   localparam int TC1_DIV     = 100;
   localparam int INIT_FRAC   = 8;
   localparam int FINE_FRAC   = 10;
   localparam int FACTOR_FRAC = 16;
   localparam int SEG_SHIFT   = 12;
   localparam int LOC_SHIFT   = 3;
   localparam int LIN_SHIFT   = 2;
   localparam int LOC_BIAS    = 4096;

   typedef struct packed {
      logic signed [15:0] flux;
      logic signed [7:0]  delta_t;
   } sample_t;

endpackage

// File: rtl/hall_comp_linearizer.sv
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
module hall_comp_linearizer #(
   parameter logic signed [15:0] INIT_GAIN = 16'sh0100
) (
   input  wire logic                   SYS_CLK,
   input  wire logic                   NRST,
   input  wire logic                   PSEL,
   input  wire logic                   PENABLE,
   input  wire logic                   PWRITE,
   input  wire logic [7:0]             PADDR,
   input  wire logic [31:0]            PWDATA,
   output logic      [31:0]            PRDATA,
   output logic                        PREADY,
   output logic                        PSLVERR,
   input  wire logic                   SAMPLE_VALID,
   input  wire hall_lin_pkg::sample_t  SAMPLE,
   output logic                        OUT_VALID,
   output logic      [15:0]            OUT_DATA
);

   function automatic logic signed [15:0] sat16(input logic signed [79:0] v);
      if (v > 80'sh7FFF) begin
         sat16 = 16'sh7FFF;
      end else if (v < -80'sh8000) begin
         sat16 = -16'sh8000;
      end else begin
         sat16 = v[15:0];
      end
   endfunction

   // register file
   logic [25:0]        sens_q;
   logic [25:0]        tc1_q;
   logic [25:0]        tc2_q;
   logic [25:0]        qo_q;
   logic [25:0]        drift_q;
   logic [25:0]        lin_q [hall_lin_pkg::NUM_WORDS];
   logic [31:0]        prdata_q;
   logic               pslverr_q;

   // pipeline
   logic               v1_q;
   logic               v2_q;
   logic               v3_q;
   logic signed [15:0] y1_q;
   logic signed [15:0] y2_q;
   logic signed [15:0] out_q;
   logic signed [7:0]  dt1_q;
   logic               hot1_q;
   logic               hot_st_q;
   logic               dec_st_q;
   logic signed [15:0] prev_x_q;

   logic [5:0]         idx;
   logic               aligned;
   logic               setup;
   logic               access;
   logic               hit_lin;
   logic [3:0]         lin_idx;

   assign idx     = PADDR[7:2];
   assign aligned = (PADDR[1:0] == 2'b00);
   assign setup   = PSEL && !PENABLE;
   assign access  = PSEL && PENABLE;
   assign hit_lin = (idx >= hall_lin_pkg::IDX_LIN_FIRST) && (idx <= hall_lin_pkg::IDX_LIN_LAST);
   assign lin_idx = 4'(idx - hall_lin_pkg::IDX_LIN_FIRST);

   // zero-wait slave, read data captured in setup cycle
   assign PREADY  = 1'b1;
   assign PRDATA  = prdata_q;
   assign PSLVERR = pslverr_q && access;

   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         prdata_q  <= 32'h00000000;
         pslverr_q <= 1'b0;
      end else if (setup) begin
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h00000000;
         if (!aligned) begin
            pslverr_q <= 1'b1;
         end else if (hit_lin) begin
            prdata_q <= {6'h00, lin_q[lin_idx]};
         end else begin
            case (idx)
               hall_lin_pkg::IDX_SENS_TRIM: prdata_q <= {6'h00, sens_q};
               hall_lin_pkg::IDX_TC1:       prdata_q <= {6'h00, tc1_q};
               hall_lin_pkg::IDX_TC2:       prdata_q <= {6'h00, tc2_q};
               hall_lin_pkg::IDX_QO:        prdata_q <= {6'h00, qo_q};
               hall_lin_pkg::IDX_DRIFT:     prdata_q <= {6'h00, drift_q};
               hall_lin_pkg::IDX_STATUS:    prdata_q <= {14'h0000, dec_st_q, hot_st_q, out_q};
               default:                     pslverr_q <= 1'b1;
            endcase
         end
      end
   end

   // writes land at the access edge
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         sens_q  <= hall_lin_pkg::SENS_TRIM_RST;
         tc1_q   <= hall_lin_pkg::WORD_RST;
         tc2_q   <= hall_lin_pkg::WORD_RST;
         qo_q    <= hall_lin_pkg::WORD_RST;
         drift_q <= hall_lin_pkg::WORD_RST;
         for (int i = 0; i < hall_lin_pkg::NUM_WORDS; i++) begin
            lin_q[i] <= hall_lin_pkg::WORD_RST;
         end
      end else if (access && PWRITE && aligned) begin
         if (hit_lin) begin
            lin_q[lin_idx] <= PWDATA[25:0];
         end else begin
            case (idx)
               hall_lin_pkg::IDX_SENS_TRIM: sens_q  <= PWDATA[25:0];
               hall_lin_pkg::IDX_TC1:       tc1_q   <= PWDATA[25:0];
               hall_lin_pkg::IDX_TC2:       tc2_q   <= PWDATA[25:0];
               hall_lin_pkg::IDX_QO:        qo_q    <= PWDATA[25:0];
               hall_lin_pkg::IDX_DRIFT:     drift_q <= PWDATA[25:0];
               default:                     ;
            endcase
         end
      end
   end

   // stage 1: temperature-segmented gain
   logic signed [15:0] y1_d;
   logic               hot_d;

   always_comb begin
      logic signed [9:0]  tc2;
      logic signed [10:0] tc1;
      logic signed [47:0] dt48;
      logic signed [47:0] f;
      logic signed [79:0] p;
      logic [2:0]         coarse;
      logic [10:0]        fine;
      tc2    = '0;
      tc1    = '0;
      dt48   = 48'(SAMPLE.delta_t);
      f      = '0;
      p      = '0;
      coarse = sens_q[hall_lin_pkg::COARSE_LSB +: hall_lin_pkg::COARSE_W];
      fine   = sens_q[hall_lin_pkg::FINE_LSB +: hall_lin_pkg::FINE_W];
      hot_d  = (SAMPLE.delta_t >= 8'sh00);
      if (hot_d) begin
         tc2 = tc2_q[0 +: hall_lin_pkg::TC2_W];
         tc1 = tc1_q[0 +: hall_lin_pkg::TC1_W];
      end else begin
         tc2 = tc2_q[hall_lin_pkg::COOL_LSB +: hall_lin_pkg::TC2_W];
         tc1 = tc1_q[hall_lin_pkg::COOL_LSB +: hall_lin_pkg::TC1_W];
      end
      // factor in Q16: 1 + (tc2/1000*dT + tc1)*dT/100
      f = (48'(tc2) * dt48 <<< hall_lin_pkg::FACTOR_FRAC) / 48'sd1000;
      f = f + (48'(tc1) <<< hall_lin_pkg::FACTOR_FRAC);
      f = (f * dt48) / 48'sd100;
      f = f + (48'sd1 <<< hall_lin_pkg::FACTOR_FRAC);
      p = 80'(SAMPLE.flux) * 80'(INIT_GAIN);
      p = p * ($signed(80'(coarse)) + 80'sd1);
      p = p * $signed(80'(fine));
      p = p * 80'(f);
      p = p >>> (hall_lin_pkg::INIT_FRAC + hall_lin_pkg::FINE_FRAC
                 + hall_lin_pkg::FACTOR_FRAC);
      if (sens_q[hall_lin_pkg::POL_BIT]) begin
         p = -p;
      end
      y1_d = sat16(p);
   end

   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         v1_q   <= 1'b0;
         y1_q   <= 16'sh0000;
         dt1_q  <= 8'sh00;
         hot1_q <= 1'b1;
      end else begin
         v1_q <= SAMPLE_VALID;
         if (SAMPLE_VALID) begin
            y1_q   <= y1_d;
            dt1_q  <= SAMPLE.delta_t;
            hot1_q <= hot_d;
         end
      end
   end

   // stage 2: offset and drift
   logic signed [15:0] y2_d;

   always_comb begin
      logic signed [17:0] qo;
      logic signed [11:0] drift;
      drift = '0;
      qo = qo_q[0 +: hall_lin_pkg::QO_W];
      if (hot1_q) begin
         drift = drift_q[0 +: hall_lin_pkg::DRIFT_W];
      end else begin
         drift = drift_q[hall_lin_pkg::COOL_LSB +: hall_lin_pkg::DRIFT_W];
      end
      y2_d = sat16(80'(y1_q) + 80'(qo) + 80'(drift) * 80'(dt1_q));
   end

   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         v2_q <= 1'b0;
         y2_q <= 16'sh0000;
      end else begin
         v2_q <= v1_q;
         if (v1_q) begin
            y2_q <= y2_d;
         end
      end
   end

   // stage 3: linearization table
   logic signed [12:0] ent [hall_lin_pkg::NUM_ENTRIES];

   for (genvar e = 0; e < hall_lin_pkg::NUM_ENTRIES; e++) begin : g_ent
      if (e % 2 == 0) begin : g_even
         assign ent[e] = lin_q[e / 2][0 +: hall_lin_pkg::ENTRY_W];
      end else begin : g_odd
         assign ent[e] = lin_q[e / 2][hall_lin_pkg::ODD_LSB +: hall_lin_pkg::ENTRY_W];
      end
   end

   logic [25:0]        ctl;
   logic signed [15:0] x;
   logic               dec;
   logic signed [15:0] lin_d;

   assign ctl = lin_q[hall_lin_pkg::NUM_WORDS - 1];
   assign x   = ctl[hall_lin_pkg::IN_INV_BIT] ? sat16(-80'(y2_q)) : y2_q;
   assign dec = (x < prev_x_q);

   always_comb begin
      logic [15:0]        ux;
      logic [4:0]         seg;
      logic [11:0]        frac;
      logic signed [31:0] d0;
      logic signed [31:0] d1;
      logic signed [31:0] thr;
      logic signed [31:0] hyst;
      logic [3:0]         cnt;
      logic signed [15:0] y;
      thr   = '0;
      ux    = {~x[15], x[14:0]};
      seg   = {1'b0, ux[15:hall_lin_pkg::SEG_SHIFT]};
      frac  = ux[hall_lin_pkg::SEG_SHIFT - 1:0];
      d0    = 32'(ent[seg]) <<< hall_lin_pkg::LIN_SHIFT;
      d1    = 32'(ent[5'(seg + 5'd1)]) <<< hall_lin_pkg::LIN_SHIFT;
      if (ctl[hall_lin_pkg::SCALE_BIT]) begin
         d0 = d0 <<< 1;
         d1 = d1 <<< 1;
      end
      d0   = d0 + (((d1 - d0) * $signed(32'(frac))) >>> hall_lin_pkg::SEG_SHIFT);
      hyst = dec ? $signed(32'(ctl[hall_lin_pkg::HYST_LSB +: hall_lin_pkg::HYST_W])) <<< 1
                 : 32'sd0;
      cnt  = 4'h0;
      for (int b = 0; b < hall_lin_pkg::NUM_BINS; b++) begin
         thr = (($signed(32'(ent[b][12:0])) - 32'sd4096) <<< hall_lin_pkg::LOC_SHIFT) - hyst;
         if (32'(x) > thr) begin
            cnt = cnt + 4'h1;
         end
      end
      y = x;
      if (ctl[hall_lin_pkg::LIN_EN_BIT]) begin
         if (ctl[hall_lin_pkg::BIN_MODE_BIT]) begin
            if (cnt == 4'h0 && ent[0] != 13'sh0000) begin
               y = -16'sh8000;
            end else begin
               thr = ($signed(32'(ent[hall_lin_pkg::NUM_BINS + ((cnt == 4'h0) ? 0 : 32'(cnt) - 1)][12:0]))
                      - 32'(hall_lin_pkg::LOC_BIAS)) <<< hall_lin_pkg::LOC_SHIFT;
               y = sat16(80'(thr));
            end
         end else begin
            y = sat16(80'(x) + 80'(d0));
         end
      end
      lin_d = ctl[hall_lin_pkg::OUT_INV_BIT] ? sat16(-80'(y)) : y;
   end

   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         v3_q     <= 1'b0;
         out_q    <= 16'sh0000;
         prev_x_q <= 16'sh0000;
         hot_st_q <= 1'b1;
         dec_st_q <= 1'b0;
      end else begin
         v3_q <= v2_q;
         if (v2_q) begin
            out_q    <= lin_d;
            prev_x_q <= x;
            hot_st_q <= hot1_q;
            dec_st_q <= dec;
         end
      end
   end

   assign OUT_VALID = v3_q;
   assign OUT_DATA  = out_q;

endmodule // hall_comp_linearizer

// File: verif/hall_comp_linearizer_asserts.sv
`timescale 1ns/1ps
module hall_lin_chk (
   input wire logic        SYS_CLK,
   input wire logic        NRST,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [7:0]  PADDR,
   input wire logic [31:0] PRDATA,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   input wire logic        SAMPLE_VALID,
   input wire logic        OUT_VALID,
   input wire logic [15:0] OUT_DATA
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!NRST);
   logic [5:0] idx;
   logic       hit;
   assign idx = PADDR[7:2];
   assign hit = PADDR[1:0] == 2'h0 && (idx inside {[6'h03:6'h07], [6'h0A:6'h12], 6'h20});
   sequence s_acc;
      PSEL && !PENABLE ##1 PSEL && PENABLE;
   endsequence
   AST_LATENCY: assert property (SAMPLE_VALID |-> ##3 OUT_VALID)
      else $error("result missing three cycles after sample");
   AST_NO_EXTRA: assert property (OUT_VALID |-> $past(SAMPLE_VALID, 3))
      else $error("result without a sample");
   AST_HOLD: assert property ($changed(OUT_DATA) |-> OUT_VALID)
      else $error("output data changed without valid");
   AST_READY: assert property (PSEL && PENABLE |-> PREADY)
      else $error("no ready in access phase");
   AST_ERR_MAP: assert property (s_acc |-> PSLVERR == !hit)
      else $error("error flag does not match address map");
   AST_ERR_ONLY: assert property (PSLVERR |-> PSEL && PENABLE)
      else $error("error flag outside access phase");
   AST_RD_UNMAP: assert property (s_acc ##0 (!PWRITE && !hit) |-> PRDATA == 32'h0)
      else $error("unmapped read returned data");
   AST_TOP_ZERO: assert property (s_acc ##0 !PWRITE |-> PRDATA[31:26] == 6'h00)
      else $error("read data above bit 25 not zero");
endmodule // hall_lin_chk

bind hall_comp_linearizer hall_lin_chk chk (.SYS_CLK(SYS_CLK), .NRST(NRST), .PSEL(PSEL),
   .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
   .PSLVERR(PSLVERR), .SAMPLE_VALID(SAMPLE_VALID), .OUT_VALID(OUT_VALID),
   .OUT_DATA(OUT_DATA));

// File: verif/hall_sample_src.sv
`timescale 1ns/1ps
module hall_sample_src (
   input  wire logic             clk,
   output logic                  valid,
   output hall_lin_pkg::sample_t smp
);
   initial begin
      valid = 1'b0;
      smp   = '0;
   end
   task automatic send(input logic [15:0] f, input logic [7:0] t);
      @(posedge clk);
      valid <= 1'b1;
      smp   <= {f, t};
      @(posedge clk);
      valid <= 1'b0;
      // idle bus shows inverse of last sample
      smp   <= ~{f, t};
   endtask
endmodule // hall_sample_src

// File: verif/hall_comp_linearizer_tb.sv
`timescale 1ns/1ps
module hall_comp_linearizer_tb;
   logic                  clk = 1'b0;
   logic                  nrst = 1'b0;
   logic                  psel = 1'b0;
   logic                  penable = 1'b0;
   logic                  pwrite = 1'b0;
   logic [7:0]            paddr = 8'h00;
   logic [31:0]           pwdata = 32'h0;
   logic [31:0]           prdata;
   logic                  pready;
   logic                  pslverr;
   logic                  sv;
   logic                  ov;
   hall_lin_pkg::sample_t smp;
   logic [15:0]           od;
   logic [31:0]           rdat;
   logic                  rerr;
   int                    bad_count = 0;
   int                    n_checks = 0;
   always #12.5 clk = ~clk;
   hall_sample_src src (.clk(clk), .valid(sv), .smp(smp));
   hall_comp_linearizer dut (.SYS_CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .SAMPLE_VALID(sv), .SAMPLE(smp), .OUT_VALID(ov), .OUT_DATA(od));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int   n;
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      // taken at the edge that samples pready high
      rdat = prdata;
      rerr = pslverr;
      if (pready !== 1'b1) begin
         bad_count++;
      end
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic er = 1'b0);
      apb(1'b0, a, 32'h0);
      chk(rdat, e);
      chk({31'h0, rerr}, {31'h0, er});
   endtask
   task automatic samp(input logic [15:0] f, input logic [7:0] t, input logic [15:0] e);
      int n;
      src.send(f, t);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (ov !== 1'b1 && n < 8);
      chk({31'h0, ov}, 32'h1);
      chk({16'h0, od}, {16'h0, e});
      @(posedge clk);
   endtask
   task automatic report_and_stop;
      $display("checks=%0d mismatches=%0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      report_and_stop();
   end
   initial begin
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      rd(8'h0C, 32'h400);
      rd(8'h10, 32'h0);
      rd(8'h20, 32'h0, 1'b1);
      rd(8'h0D, 32'h0, 1'b1);
      samp(16'h1234, 8'h00, 16'h1234);
      wr(8'h0C, 32'h8400);
      samp(16'h0100, 8'h00, 16'hFF00);
      wr(8'h0C, 32'h1400);
      samp(16'h1000, 8'h00, 16'h2000);
      samp(16'h7000, 8'h00, 16'h7FFF);
      samp(16'h9000, 8'h00, 16'h8000);
      wr(8'h0C, 32'h0400);
      wr(8'h10, 32'h2001);
      samp(16'h03E8, 8'h64, 16'h07D0);
      samp(16'h03E8, 8'hCE, 16'h0000);
      wr(8'h10, 32'h0);
      wr(8'h14, 32'h1400A);
      samp(16'h03E8, 8'h64, 16'h07D0);
      samp(16'h03E8, 8'hCE, 16'h05DC);
      wr(8'h14, 32'h0);
      wr(8'h18, 32'h3FFFB);
      samp(16'h1000, 8'h00, 16'h0FFB);
      wr(8'h18, 32'h0);
      wr(8'h1C, 32'h3002);
      samp(16'h1000, 8'h04, 16'h1008);
      samp(16'h1000, 8'hFC, 16'h0FF4);
      wr(8'h1C, 32'h0);
      wr(8'h38, 32'hFC200000);
      rd(8'h38, 32'h0200000);
      wr(8'h48, 32'h2000);
      samp(16'h0000, 8'h00, 16'h0000);
      samp(16'h0800, 8'h00, 16'h0A00);
      samp(16'h1000, 8'h00, 16'h1400);
      wr(8'h48, 32'h2002000);
      samp(16'h0800, 8'h00, 16'h0C00);
      // bin table with rising locations
      wr(8'h28, 32'h3FFF000);
      for (int i = 0; i < 3; i++) begin
         wr(8'h2C + 8'(i * 4), 32'h3FFFFFF);
      end
      wr(8'h38, 32'h1064);
      wr(8'h48, 32'h146000);
      samp(16'h0005, 8'h00, 16'h0320);
      samp(16'hFFFB, 8'h00, 16'h0320);
      samp(16'hFFE2, 8'h00, 16'h8000);
      samp(16'hFFFB, 8'h00, 16'h8000);
      samp(16'h0005, 8'h00, 16'h0320);
      rd(8'h80, 32'h10320);
      report_and_stop();
   end
endmodule // hall_comp_linearizer_tb
